/* include/tcamr_pkg.sv */
/*
 * constants, types and the linear-11 decoder for the
 * temperature calibration and alert mask register bank.
 * assumes: fixed point results carry 16 fraction bits.
 */
package tcamr_pkg;

    typedef logic signed [47:0] tcamr_q_t;

    localparam int PAGES = 2;
    localparam int MASK_BYTES = 7;
    localparam int FRAC = 16;
    localparam int DIV_BITS = 48;

    // command codes
    localparam logic [7:0] CMD_EXT_TEMP_GAIN = 8'hd9;
    localparam logic [7:0] CMD_EXT_TEMP_BIAS = 8'hda;
    localparam logic [7:0] CMD_ALERT_MASK = 8'hdb;
    localparam logic [7:0] CMD_SENSE_TC = 8'hdc;

    // reset values
    localparam logic [15:0] GAIN_RST = 16'hba00;
    localparam logic [15:0] BIAS_RST = 16'h0000;
    localparam logic [55:0] MASK_RST = 56'h00_0000_0000_0000;
    localparam logic [7:0] TC_RST = 8'h00;

    // field positions
    localparam int TC_SRC_BIT = 7;
    localparam int TC_COEF_MSB = 6;
    localparam int UNUSED_MASK_BYTE = 5;

    // accepted ranges, q16.16
    localparam tcamr_q_t GAIN_MIN_Q = 48'sh0000_0000_199a;
    localparam tcamr_q_t GAIN_MAX_Q = 48'sh0000_000a_0000;
    localparam tcamr_q_t BIAS_MIN_Q = 48'shffff_ff9c_0000;
    localparam tcamr_q_t BIAS_MAX_Q = 48'sh0000_0064_0000;

    // tempco arithmetic
    localparam tcamr_q_t ONE_Q = 48'sh0000_0001_0000;
    localparam tcamr_q_t TREF_Q = 48'sh0000_0019_0000;
    localparam logic [15:0] PPM_STEP_Q26 = 16'h1a37;
    localparam int PPM_SHIFT = 26;

    // mantissa times two to the exponent, in q16.16
    function automatic tcamr_q_t lin11_to_q(input logic [15:0] v);
        logic signed [4:0] e;
        tcamr_q_t m;
        int sh;
        e = v[15:11];
        m = 48'(signed'(v[10:0]));
        sh = int'(e) + FRAC;
        if (sh >= 0)
        begin
            return m <<< sh;
        end
        return m >>> (-sh);
    endfunction

endpackage

/* include/tcamr_div_if.sv */
/*
 * handshake between the calibration sequencer and the
 * unsigned divider.
 * assumes: one clock shared by both ends.
 */
`timescale 1ns/1ps
interface tcamr_div_if;
    logic start;
    logic [47:0] dividend;
    logic [31:0] divisor;
    logic done;
    logic [47:0] quotient;

    modport master (
        output start,
        output dividend,
        output divisor,
        input done,
        input quotient
    );
    modport slave (
        input start,
        input dividend,
        input divisor,
        output done,
        output quotient
    );
endinterface

/* src/tcamr_divider.sv */
/*
 * restoring unsigned divider, one quotient bit a cycle.
 * assumes: divisor is non zero; start only while idle.
 */
`timescale 1ns/1ps
module tcamr_divider (
    input wire logic clk,          // system clock
    input wire logic reset,        // async, active high
    tcamr_div_if.slave div         // operands and result
);
    localparam int N = tcamr_pkg::DIV_BITS;

    logic [N:0] rem_r, rem_nxt;
    logic [N-1:0] quo_r, quo_nxt;
    logic [31:0] dsr_r, dsr_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;

    always_comb
    begin
        logic [N:0] sh;
        sh = {rem_r[N-1:0], quo_r[N-1]};
        rem_nxt = rem_r;
        quo_nxt = quo_r;
        dsr_nxt = dsr_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (!busy_r && div.start)
        begin
            rem_nxt = '0;
            quo_nxt = div.dividend;
            dsr_nxt = div.divisor;
            cnt_nxt = 6'(N - 1);
            busy_nxt = 1'b1;
        end
        else if (busy_r)
        begin
            if (sh >= {17'h0_0000, dsr_r})
            begin
                rem_nxt = sh - {17'h0_0000, dsr_r};
                quo_nxt = {quo_r[N-2:0], 1'b1};
            end
            else
            begin
                rem_nxt = sh;
                quo_nxt = {quo_r[N-2:0], 1'b0};
            end
            cnt_nxt = cnt_r - 6'h01;
            if (cnt_r == 6'h00)
            begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rem_r <= '0;
            quo_r <= '0;
            dsr_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            rem_r <= rem_nxt;
            quo_r <= quo_nxt;
            dsr_r <= dsr_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign div.done = done_r;
    assign div.quotient = quo_r;
endmodule

/* src/tcamr_alert_gate.sv */
/*
 * gates fault status onto the alert pin through the mask.
 * assumes: status bytes are levels from the fault logic.
 */
`timescale 1ns/1ps
module tcamr_alert_gate #(
    parameter int BYTES = tcamr_pkg::MASK_BYTES
) (
    input wire logic clk,                  // system clock
    input wire logic reset,                // async, active high
    input wire logic [8*BYTES-1:0] status, // fault status bytes
    input wire logic [8*BYTES-1:0] mask,   // alert mask bytes
    output logic [8*BYTES-1:0] held,       // status, unmasked
    output logic response_req,             // any fault, unmasked
    output logic alert                     // masked alert level
);
    logic [8*BYTES-1:0] held_r, held_nxt;
    logic resp_r, resp_nxt;
    logic alert_r, alert_nxt;

    always_comb
    begin
        logic [8*BYTES-1:0] eff;
        eff = mask;
        eff[8*tcamr_pkg::UNUSED_MASK_BYTE +: 8] = 8'h00;
        held_nxt = status;
        resp_nxt = |status;
        alert_nxt = |(status & ~eff);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            held_r <= '0;
            resp_r <= 1'b0;
            alert_r <= 1'b0;
        end
        else
        begin
            held_r <= held_nxt;
            resp_r <= resp_nxt;
            alert_r <= alert_nxt;
        end
    end

    assign held = held_r;
    assign response_req = resp_r;
    assign alert = alert_r;
endmodule

/* src/tcamr_top.sv */
/*
 * paged external temperature calibration, alert mask and
 * current sense tempco registers, with their arithmetic.
 * assumes: a transaction layer delivers decoded commands
 * one at a time; all inputs are synchronous to clk.
 */
`timescale 1ns/1ps
module tcamr_top #(
    parameter int PAGES = tcamr_pkg::PAGES,
    localparam int PW = (PAGES > 1) ? $clog2(PAGES) : 1
) (
    input wire logic clk,                      // 100 MHz clock
    input wire logic reset,                    // async, active high
    input wire logic cmd_valid,                // command strobe
    input wire logic cmd_write,                // 1 write, 0 read
    input wire logic [7:0] cmd_code,           // command code
    input wire logic [PW-1:0] cmd_page,        // current page
    input wire logic [55:0] cmd_wdata,         // write data, low bytes
    output logic rsp_valid,                    // answer strobe
    output logic rsp_err,                      // command refused
    output logic [55:0] rsp_rdata,             // read data
    input wire logic [15:0] ext_temp_l11,      // external sensor reading
    input wire logic [15:0] int_temp_l11,      // internal sensor reading
    input wire logic [PAGES-1:0][15:0] iout_cal_gain_l11, // cal gain
    input wire logic [55:0] fault_status,      // fault status bytes
    output logic [PAGES-1:0][31:0] read_temp2_q,  // q16.16 temperature
    output logic [PAGES-1:0][31:0] sense_res_q,   // q16.16 resistance
    output logic [55:0] fault_status_held,     // registered status
    output logic fault_response_req,           // any fault present, mask ignored
    input wire logic alert_out_pin_i,          // alert wire level
    output logic alert_out_pin_o,              // alert drive value
    output logic alert_out_pin_oe_n            // low while pulling
);

    //--------------------------------------------
    // types and helpers
    //--------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV = 3'b010,
        ST_STORE = 3'b100
    } tcamr_state_e;

    function automatic tcamr_pkg::tcamr_q_t q_mul(
        input tcamr_pkg::tcamr_q_t a,
        input tcamr_pkg::tcamr_q_t b,
        input int sh
    );
        logic signed [95:0] p;
        p = 96'(a) * 96'(b);
        return 48'(p >>> sh);
    endfunction

    function automatic logic in_range(
        input tcamr_pkg::tcamr_q_t v,
        input tcamr_pkg::tcamr_q_t lo,
        input tcamr_pkg::tcamr_q_t hi
    );
        return (v >= lo) && (v <= hi);
    endfunction

    //--------------------------------------------
    // register file
    //--------------------------------------------
    logic [15:0] gain_r [PAGES];
    logic [15:0] gain_nxt [PAGES];
    logic [15:0] bias_r [PAGES];
    logic [15:0] bias_nxt [PAGES];
    logic [7:0] tc_r [PAGES];
    logic [7:0] tc_nxt [PAGES];
    logic [55:0] mask_r, mask_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic rsp_err_r, rsp_err_nxt;
    logic [55:0] rdata_r, rdata_nxt;

    always_comb
    begin
        logic page_ok;
        tcamr_pkg::tcamr_q_t wq;
        page_ok = (int'(cmd_page) < PAGES);
        wq = tcamr_pkg::lin11_to_q(cmd_wdata[15:0]);
        gain_nxt = gain_r;
        bias_nxt = bias_r;
        tc_nxt = tc_r;
        mask_nxt = mask_r;
        rsp_valid_nxt = cmd_valid;
        rsp_err_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (cmd_valid)
        begin
            rdata_nxt = '0;
            unique case (cmd_code)
                tcamr_pkg::CMD_EXT_TEMP_GAIN:
                begin
                    if (!page_ok)
                    begin
                        rsp_err_nxt = 1'b1;
                    end
                    else if (!cmd_write)
                    begin
                        rdata_nxt[15:0] = gain_r[cmd_page];
                    end
                    else if (in_range(wq, tcamr_pkg::GAIN_MIN_Q,
                                      tcamr_pkg::GAIN_MAX_Q))
                    begin
                        gain_nxt[cmd_page] = cmd_wdata[15:0];
                    end
                    else
                    begin
                        rsp_err_nxt = 1'b1;
                    end
                end
                tcamr_pkg::CMD_EXT_TEMP_BIAS:
                begin
                    if (!page_ok)
                    begin
                        rsp_err_nxt = 1'b1;
                    end
                    else if (!cmd_write)
                    begin
                        rdata_nxt[15:0] = bias_r[cmd_page];
                    end
                    else if (in_range(wq, tcamr_pkg::BIAS_MIN_Q,
                                      tcamr_pkg::BIAS_MAX_Q))
                    begin
                        bias_nxt[cmd_page] = cmd_wdata[15:0];
                    end
                    else
                    begin
                        rsp_err_nxt = 1'b1;
                    end
                end
                tcamr_pkg::CMD_ALERT_MASK:
                begin
                    if (cmd_write)
                    begin
                        mask_nxt = cmd_wdata;
                    end
                    else
                    begin
                        rdata_nxt = mask_r;
                    end
                end
                tcamr_pkg::CMD_SENSE_TC:
                begin
                    if (!page_ok)
                    begin
                        rsp_err_nxt = 1'b1;
                    end
                    else if (cmd_write)
                    begin
                        tc_nxt[cmd_page] = cmd_wdata[7:0];
                    end
                    else
                    begin
                        rdata_nxt[7:0] = tc_r[cmd_page];
                    end
                end
                default:
                begin
                    rsp_err_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int p = 0; p < PAGES; p++)
            begin
                gain_r[p] <= tcamr_pkg::GAIN_RST;
                bias_r[p] <= tcamr_pkg::BIAS_RST;
                tc_r[p] <= tcamr_pkg::TC_RST;
            end
            mask_r <= tcamr_pkg::MASK_RST;
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
            rdata_r <= '0;
        end
        else
        begin
            gain_r <= gain_nxt;
            bias_r <= bias_nxt;
            tc_r <= tc_nxt;
            mask_r <= mask_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_err_r <= rsp_err_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_err = rsp_err_r;
    assign rsp_rdata = rdata_r;

    //--------------------------------------------
    // calibration sequencer, pages in turn
    //--------------------------------------------
    tcamr_div_if div_if ();

    tcamr_divider u_div (
        .clk(clk),
        .reset(reset),
        .div(div_if.slave)
    );

    tcamr_state_e state_r, state_nxt;
    logic [PW-1:0] pg_r, pg_nxt;
    logic neg_r, neg_nxt;
    logic [31:0] temp2_r [PAGES];
    logic [31:0] temp2_nxt [PAGES];
    logic [31:0] sense_resistance_r [PAGES];
    logic [31:0] sense_resistance_nxt [PAGES];

    tcamr_pkg::tcamr_q_t ext_q;
    tcamr_pkg::tcamr_q_t ext_mag;
    assign ext_q = tcamr_pkg::lin11_to_q(ext_temp_l11);
    assign ext_mag = ext_q[47] ? -ext_q : ext_q;

    // dividend pre-scaled so the quotient stays q16.16
    assign div_if.start = (state_r == ST_IDLE);
    assign div_if.dividend = 48'(ext_mag <<< tcamr_pkg::FRAC);
    assign div_if.divisor = 32'(tcamr_pkg::lin11_to_q(gain_r[pg_r]));

    always_comb
    begin
        tcamr_pkg::tcamr_q_t quo;
        tcamr_pkg::tcamr_q_t t_sel;
        tcamr_pkg::tcamr_q_t corr;
        tcamr_pkg::tcamr_q_t coef;
        quo = 48'(signed'({1'b0, div_if.quotient[46:0]}));
        coef = 48'(signed'({1'b0, tc_r[pg_r][tcamr_pkg::TC_COEF_MSB:0]}));
        t_sel = tc_r[pg_r][tcamr_pkg::TC_SRC_BIT]
              ? ext_q : tcamr_pkg::lin11_to_q(int_temp_l11);
        // tc * 100 ppm * (T - 25), in q16.16
        corr = q_mul(coef * (t_sel - tcamr_pkg::TREF_Q),
                     48'(tcamr_pkg::PPM_STEP_Q26),
                     tcamr_pkg::PPM_SHIFT);
        state_nxt = state_r;
        pg_nxt = pg_r;
        neg_nxt = neg_r;
        temp2_nxt = temp2_r;
        sense_resistance_nxt = sense_resistance_r;
        unique case (state_r)
            ST_IDLE:
            begin
                neg_nxt = ext_q[47];
                state_nxt = ST_DIV;
            end
            ST_DIV:
            begin
                if (div_if.done)
                begin
                    state_nxt = ST_STORE;
                end
            end
            ST_STORE:
            begin
                temp2_nxt[pg_r] = 32'((neg_r ? -quo : quo)
                    + tcamr_pkg::lin11_to_q(bias_r[pg_r]));
                // resistance rises with T so current reads fall back
                sense_resistance_nxt[pg_r] = 32'(q_mul(
                    tcamr_pkg::lin11_to_q(iout_cal_gain_l11[pg_r]),
                    tcamr_pkg::ONE_Q + corr,
                    tcamr_pkg::FRAC));
                pg_nxt = (int'(pg_r) == PAGES - 1) ? '0 : PW'(pg_r + 1'b1);
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE;
            pg_r <= '0;
            neg_r <= 1'b0;
            for (int p = 0; p < PAGES; p++)
            begin
                temp2_r[p] <= '0;
                sense_resistance_r[p] <= '0;
            end
        end
        else
        begin
            state_r <= state_nxt;
            pg_r <= pg_nxt;
            neg_r <= neg_nxt;
            temp2_r <= temp2_nxt;
            sense_resistance_r <= sense_resistance_nxt;
        end
    end

    always_comb
    begin
        for (int p = 0; p < PAGES; p++)
        begin
            read_temp2_q[p] = temp2_r[p];
            sense_res_q[p] = sense_resistance_r[p];
        end
    end

    //--------------------------------------------
    // alert pin
    //--------------------------------------------
    logic alert_act;

    tcamr_alert_gate #(
        .BYTES(tcamr_pkg::MASK_BYTES)
    ) u_alert (
        .clk(clk),
        .reset(reset),
        .status(fault_status),
        .mask(mask_r),
        .held(fault_status_held),
        .response_req(fault_response_req),
        .alert(alert_act)
    );

    // open drain: pull low while a fault is unmasked
    assign alert_out_pin_o = 1'b0;
    assign alert_out_pin_oe_n = ~alert_act;

endmodule

/* tb/tcamr_checker.sv */
/*
 * concurrent checks on the command, status and alert ports of the bank.
 * assumes: bound into tcamr_top; one clock domain, async active-high reset.
 */
`timescale 1ns/1ps
module tcamr_checker #(
    parameter int PAGES = 2,
    localparam int PW = (PAGES > 1) ? $clog2(PAGES) : 1
) (
    input wire logic clk,                 // system clock
    input wire logic reset,               // async, active high
    input wire logic cmd_valid,           // command strobe
    input wire logic cmd_write,           // 1 write
    input wire logic [7:0] cmd_code,      // command code
    input wire logic [PW-1:0] cmd_page,   // page
    input wire logic [55:0] cmd_wdata,    // write data
    input wire logic rsp_valid,           // answer strobe
    input wire logic rsp_err,             // refused
    input wire logic [55:0] rsp_rdata,    // read data
    input wire logic [55:0] fault_status, // status bytes
    input wire logic [55:0] fault_status_held, // registered status
    input wire logic fault_response_req,  // any fault, mask ignored
    input wire logic alert_out_pin_oe_n   // low while pulling
);
    // --------
    // mask shadow
    // --------
    logic [55:0] mask_r;
    logic [55:0] mask_nxt;
    logic mask_wr;
    logic unm;
    assign mask_wr = cmd_valid && cmd_write && cmd_code == 8'hdb;
    // byte 5 of the mask never hides anything
    assign unm = |(fault_status & ~(mask_r & 56'hff_00ff_ffff_ffff));
    always_comb
    begin
        mask_nxt = mask_wr ? cmd_wdata : mask_r;
    end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mask_r <= '0;
        else
            mask_r <= mask_nxt;
    end
    // --------
    // assertions
    // --------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    AST_RSP_NEXT: assert property (cmd_valid |=> rsp_valid)
        else $error("command not answered next cycle");
    AST_RSP_QUIET: assert property (!cmd_valid |=> !rsp_valid)
        else $error("answer without command");
    AST_GAIN_NEG: assert property (cmd_valid && cmd_write && cmd_code == 8'hd9
        && cmd_wdata[10] |=> rsp_err) else $error("negative gain accepted");
    AST_BIAS_RANGE: assert property (cmd_valid && cmd_write && cmd_code == 8'hda
        && cmd_wdata[15:10] == 6'h00 |=> rsp_err == ($past(cmd_wdata[9:0]) > 10'd100))
        else $error("offset range decision wrong");
    AST_READ_OK: assert property (cmd_valid && !cmd_write
        && cmd_code inside {[8'hd9:8'hdc]} |=> !rsp_err) else $error("read refused");
    AST_MASK_BACK: assert property (!$past(reset) && $past(mask_wr) && cmd_valid
        && !cmd_write && cmd_code == 8'hdb |=> rsp_rdata == $past(cmd_wdata, 2))
        else $error("mask readback differs");
    AST_TC_BACK: assert property (!$past(reset) && $past(cmd_valid && cmd_write
        && cmd_code == 8'hdc) && cmd_valid && !cmd_write && cmd_code == 8'hdc
        && cmd_page == $past(cmd_page) |=> rsp_rdata == {48'h0, $past(cmd_wdata[7:0], 2)})
        else $error("tempco readback differs");
    AST_ALERT_ON: assert property ((unm && !mask_wr)[*2] |=> !alert_out_pin_oe_n)
        else $error("unmasked fault not driving alert");
    AST_ALERT_OFF: assert property ((!unm && !mask_wr)[*2] |=> alert_out_pin_oe_n)
        else $error("alert driven with all faults masked");
    AST_HELD_RAW: assert property (!$past(reset)
        |-> fault_status_held == $past(fault_status)) else $error("status not recorded");
    AST_RESP_REQ: assert property (!$past(reset)
        |-> fault_response_req == |$past(fault_status)) else $error("fault response lost");
endmodule

bind tcamr_top tcamr_checker #(.PAGES(PAGES)) i_tcamr_checker (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .fault_status(fault_status), .fault_status_held(fault_status_held),
    .fault_response_req(fault_response_req), .alert_out_pin_oe_n(alert_out_pin_oe_n)
);

/* tb/tcamr_host.sv */
/*
 * host controller model: one command per call, answer taken next edge.
 * assumes: tasks are entered just after a rising edge of clk.
 */
`timescale 1ns/1ps
module tcamr_host (
    input wire logic clk,             // system clock
    output logic cmd_valid,           // command strobe
    output logic cmd_write,           // 1 write
    output logic [7:0] cmd_code,      // command code
    output logic cmd_page,            // page
    output logic [55:0] cmd_wdata,    // write data
    input wire logic rsp_valid,       // answer strobe
    input wire logic rsp_err,         // refused
    input wire logic [55:0] rsp_rdata // read data
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_page = 1'b0;
        cmd_wdata = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic p,
        input logic [55:0] d, output logic vo, output logic eo, output logic [55:0] ro);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_page = p;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        vo = rsp_valid;
        eo = rsp_err;
        ro = rsp_rdata;
    endtask
    // idle code and write data are inverted so they carry no stale value; cmd_write and cmd_page keep theirs
    task automatic idle;
        cmd_valid = 1'b0;
        cmd_code = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule

/* tb/tb.sv */
/*
 * self-checking bench for the calibration, alert mask and tempco bank.
 * assumes: host model issues commands; checker is bound to the top.
 */
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [7:0] code; logic page; logic [55:0] wd;
        logic err; logic [55:0] rd;} tcamr_row_s;
    logic clk, reset, cmd_valid, cmd_write, cmd_page, rsp_valid, rsp_err;
    logic resp_req, pin_o, oe_n, pin, v, e;
    logic [7:0] cmd_code;
    logic [55:0] cmd_wdata, rsp_rdata, fault_status, held, r;
    logic [15:0] ext_t, int_t;
    logic [1:0][15:0] cal;
    logic [1:0][31:0] temp2, sense;
    int err_total, n_tests;
    tcamr_row_s rows [13] = '{
        '{8'hd9, 1'b0, 56'h000a, 1'b0, 56'h000a}, '{8'hd9, 1'b0, 56'h000b, 1'b1, 56'h000a},
        '{8'hd9, 1'b0, 56'hb067, 1'b0, 56'hb067}, '{8'hd9, 1'b0, 56'hb066, 1'b1, 56'hb067},
        '{8'hd9, 1'b1, 56'hc200, 1'b0, 56'hc200}, '{8'hd9, 1'b1, 56'h0400, 1'b1, 56'hc200},
        '{8'hda, 1'b1, 56'h0064, 1'b0, 56'h0064}, '{8'hda, 1'b1, 56'h0065, 1'b1, 56'h0064},
        '{8'hda, 1'b0, 56'h079c, 1'b0, 56'h079c}, '{8'hda, 1'b0, 56'h079b, 1'b1, 56'h079c},
        '{8'hdc, 1'b0, 56'h0027, 1'b0, 56'h0027}, // copper setting
        '{8'hdc, 1'b1, 56'h00ff, 1'b0, 56'h00ff},
        '{8'hdb, 1'b0, 56'h0f_0f0f_0f0f_0f0f, 1'b0, 56'h0f_0f0f_0f0f_0f0f}};

    assign pin = oe_n ? 1'b1 : pin_o;
    always #5 clk = ~clk;

    tcamr_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata));
    tcamr_top #(.PAGES(2)) i_tcamr_top (.clk(clk), .reset(reset),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .ext_temp_l11(ext_t),
        .int_temp_l11(int_t), .iout_cal_gain_l11(cal), .fault_status(fault_status),
        .read_temp2_q(temp2), .sense_res_q(sense), .fault_status_held(held),
        .fault_response_req(resp_req), .alert_out_pin_i(pin),
        .alert_out_pin_o(pin_o), .alert_out_pin_oe_n(oe_n));

    // --------
    // helpers
    // --------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic p, input logic [55:0] exp);
        u_host.xfer(1'b0, c, p, 56'h0, v, e, r);
        check("read answer", {v, e}, 2'b10);
        check("read data", r, exp);
    endtask
    task automatic rst_vals;
        for (int p = 0; p < 2; p++)
        begin
            rd(8'hd9, 1'(p), 56'(tcamr_pkg::GAIN_RST));
            rd(8'hda, 1'(p), 56'(tcamr_pkg::BIAS_RST));
            rd(8'hdc, 1'(p), 56'(tcamr_pkg::TC_RST));
        end
        rd(8'hdb, 1'b0, tcamr_pkg::MASK_RST);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // --------
    // sequence
    // --------
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        fault_status = '0;
        ext_t = 16'h007d;
        int_t = 16'h0019;
        cal = {16'h0001, 16'h0003};
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        rst_vals();
        foreach (rows[i])
        begin
            u_host.xfer(1'b1, rows[i].code, rows[i].page, rows[i].wd, v, e, r);
            check("write refusal", e, rows[i].err);
            rd(rows[i].code, rows[i].page, rows[i].rd);
        end
        rd(8'hd9, 1'b0, 56'hb067);
        u_host.xfer(1'b1, 8'hdd, 1'b0, 56'h0, v, e, r);
        check("unknown code", {v, e}, 2'b11);
        u_host.idle();
        for (int n = 0; n < 7; n++)
        begin
            for (int b = 0; b < 2; b++)
            begin
                fault_status = 56'h1 << (8 * n + 4 * b);
                repeat (3) @(posedge clk);
                #1;
                check("alert oe_n", oe_n, (b == 0 && n != 5));
                check("alert pin", pin, (b == 0 && n != 5));
                check("status held", held, fault_status);
                check("fault response", resp_req, 1'b1);
            end
        end
        fault_status = '0;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        rst_vals();
        u_host.xfer(1'b1, 8'hd9, 1'b0, 56'hc900, v, e, r);
        u_host.xfer(1'b1, 8'hda, 1'b0, 56'h0005, v, e, r);
        u_host.xfer(1'b1, 8'hdc, 1'b0, 56'h0027, v, e, r);
        u_host.xfer(1'b1, 8'hdc, 1'b1, 56'h008a, v, e, r);
        u_host.idle();
        repeat (150) @(posedge clk);
        #1;
        check("temp2 page0", temp2[0], 32'h0043_8000);
        check("temp2 page1", temp2[1], 32'h007d_0000);
        check("sense page0", sense[0], 32'h0003_0000);
        check("sense page1", sense[1] > 32'h0001_1960 && sense[1] < 32'h0001_19d0, 1'b1);
        final_report();
    end

    initial
    begin
        #100000;
        err_total++;
        final_report();
    end
endmodule
